// File: irrcd_checker.sv
/* Port checker for the command decoder top.
   Assumes one clock and an active-low asynchronous reset. */
`timescale 1ns/1ps
module irrcd_checker
	import irrcd_pkg::*;
#(
	parameter bit LARGE_VARIANT_P = 1'b1,
	parameter logic [DIV_W-1:0] TICK_CYCLES_P = DIV_W'(TICK_CYCLES),
	parameter logic [TIMER_W-1:0] HOLD_TICKS_P = TIMER_W'(HOLD_TICKS),
	parameter logic [TIMER_W-1:0] PULSE_TICKS_P = TIMER_W'(PULSE_TICKS)
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Watched ports
	input wire logic ir_command_in_i,
	input wire logic [NUM_HELD-1:0] held_output_o,
	input wire logic [NUM_SINGLE-1:0] oneshot_output_o,
	input wire logic [NUM_TOGGLE-1:0] toggle_output_o,
	input wire logic latch_o
);
	// Cycle limits from tick counts
	localparam int unsigned TK = TICK_CYCLES_P;
	localparam int unsigned HOLD_MAX = (HOLD_TICKS_P + 2) * TK;
	localparam int unsigned PW_MIN = (PULSE_TICKS_P - 1) * TK;
	localparam int unsigned PW_MAX = (PULSE_TICKS_P + 1) * TK + 1;
	logic [19:0] since_reg; // Cycles since last latch, saturating
	logic [19:0] os_reg; // Cycles first one-shot has been high
	// Helper counters
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			since_reg <= '0;
			os_reg <= '0;
		end
		else
		begin
			since_reg <= latch_o ? '0 : since_reg + 20'(since_reg != '1);
			os_reg <= oneshot_output_o[0] ? os_reg + 20'h0_0001 : '0;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	a_latch_one_cycle: assert property (latch_o |=> !latch_o)
		else $error("latch longer than one cycle");
	a_latch_after_edge: assert property (latch_o |-> $past(ir_command_in_i, 3))
		else $error("latch without input edge");
	a_held_rise_latch: assert property (
		|(held_output_o & ~$past(held_output_o)) |-> $past(latch_o))
		else $error("held output rose without latch");
	a_single_rise_latch: assert property (
		|(oneshot_output_o & ~$past(oneshot_output_o)) |-> $past(latch_o))
		else $error("one-shot rose without latch");
	a_toggle_on_latch: assert property (
		(toggle_output_o != $past(toggle_output_o)) |-> latch_o)
		else $error("toggle changed without latch");
	a_held_hold_limit: assert property (|held_output_o |-> since_reg <= HOLD_MAX)
		else $error("held output outlived hold time");
	a_pulse_width: assert property (
		$fell(oneshot_output_o[0]) |-> os_reg >= PW_MIN && os_reg <= PW_MAX)
		else $error("one-shot width wrong");
	a_small_variant: assert property (
		LARGE_VARIANT_P || (!held_output_o[5] && toggle_output_o == '0))
		else $error("small variant drove absent output");
	// Main scenarios reached
	c_latch: cover property (latch_o);
	c_held_drop: cover property ($fell(|held_output_o));
	c_toggle: cover property (toggle_output_o != $past(toggle_output_o));
endmodule
bind irrcd_top irrcd_checker #(.LARGE_VARIANT_P(LARGE_VARIANT_P), .TICK_CYCLES_P(TICK_CYCLES_P),
	.HOLD_TICKS_P(HOLD_TICKS_P), .PULSE_TICKS_P(PULSE_TICKS_P)) u_irrcd_checker (.clk_i(clk_i),
	.rstn_i(rstn_i), .ir_command_in_i(ir_command_in_i), .held_output_o(held_output_o),
	.oneshot_output_o(oneshot_output_o), .toggle_output_o(toggle_output_o), .latch_o(latch_o));

// File: irrcd_ir_tx_model.sv
/* Remote transmitter model: sends a word and its repeat as edge intervals.
   Assumes a tick of 4 clocks: 40 clocks is a zero, 160 a one, 320 a gap. */
`timescale 1ns/1ps
module irrcd_ir_tx_model
(
	// Clock
	input wire logic clk_i,
	// Demodulated line, idle low
	output logic ir_o
);
	initial ir_o = 1'b0;
	// One rising edge, next edge ivl clocks later
	task automatic pulse(input int ivl);
		@(posedge clk_i);
		ir_o <= 1'b1;
		repeat (8) @(posedge clk_i);
		ir_o <= 1'b0;
		repeat (ivl - 9) @(posedge clk_i);
	endtask
	// First word, gap, repeat word, trailing gap
	task automatic send(input logic [11:0] a, input logic [11:0] b);
		int i;
		for (i = 0; i < 26; i++)
		begin
			if (i < 12)
				pulse(a[11 - i] ? 160 : 40);
			else if (i > 12 && i < 25)
				pulse(b[24 - i] ? 160 : 40);
			else
				pulse(320);
		end
	endtask
endmodule

// File: irrcd_pkg.sv
/*
 * Shared constants and types of the infrared remote command decoder:
 * clock and oscillator rates, hold and pulse times, word field positions,
 * output counts and the receiver state encoding.
 * Assumes a 25 MHz system clock; the 38 kHz timing tick is derived from it.
 */
package irrcd_pkg;

	// System clock and internal timing oscillator
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned OSC_HZ = 38_000;
	localparam int unsigned TICK_CYCLES = CLK_HZ / OSC_HZ;
	localparam int unsigned DIV_W = 10;

	// Output times in milliseconds and in oscillator ticks
	localparam int unsigned HOLD_MS = 160;
	localparam int unsigned PULSE_MS = 107;
	localparam int unsigned HOLD_TICKS = (HOLD_MS * OSC_HZ) / 1000;
	localparam int unsigned PULSE_TICKS = (PULSE_MS * OSC_HZ) / 1000;
	localparam int unsigned TIMER_W = 13;

	// Command word layout, first received bit lands in the top bit
	localparam int unsigned WORD_W = 12;
	localparam int unsigned POS_C1 = 11;
	localparam int unsigned POS_C2 = 10;
	localparam int unsigned POS_C3 = 9;
	localparam int unsigned POS_CT = 8;
	localparam int unsigned POS_S1 = 7;
	localparam int unsigned POS_S2 = 6;
	localparam int unsigned DATA_W = 6;
	localparam int unsigned LAST_BIT = 11;

	// Output counts of the large variant and limits of the small one
	localparam int unsigned NUM_HELD = 6;
	localparam int unsigned NUM_SINGLE = 10;
	localparam int unsigned NUM_TOGGLE = 2;
	localparam int unsigned NUM_TIMERS = NUM_HELD + NUM_SINGLE;
	localparam logic [5:0] HELD_MASK_LARGE = 6'h3F;
	localparam logic [5:0] HELD_MASK_SMALL = 6'h1F;

	// Bit decoding by interval between rising edges, in ticks
	localparam int unsigned IVL_W = 8;
	localparam logic [7:0] BIT_ONE_TICKS = 8'h20;
	localparam logic [7:0] WORD_GAP_TICKS = 8'h40;
	localparam logic [7:0] TIMEOUT_TICKS = 8'hFF;

	// Receiver states, one-hot
	typedef enum logic [3:0]
	{
		RX_IDLE = 4'h1,
		RX_FIRST = 4'h2,
		RX_WAIT2 = 4'h4,
		RX_SECOND = 4'h8
	} irrcd_rx_type;

endpackage

// File: irrcd_timer_bank.sv
/*
 * Output timer bank: one down counter per held or one-shot output.
 * Held channels reload with the hold time, one-shot channels with the pulse time.
 * Assumes start pulses and ticks come from logic on the same clock.
 */
`timescale 1ns/1ps
module irrcd_timer_bank
	import irrcd_pkg::*;
#(
	parameter logic [TIMER_W-1:0] HOLD_T = TIMER_W'(HOLD_TICKS),
	parameter logic [TIMER_W-1:0] PULSE_T = TIMER_W'(PULSE_TICKS)
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Control link
	irrcd_timer_if.bank tmr
);

	// Whole state of the bank
	typedef struct packed
	{
		logic [NUM_TIMERS-1:0][TIMER_W-1:0] cnt; // Remaining ticks
		logic [NUM_TIMERS-1:0] act;              // Registered activity
	} irrcd_bank_type;

	irrcd_bank_type state_reg;
	irrcd_bank_type state_next;
	logic [NUM_TIMERS-1:0][TIMER_W-1:0] cnt_next; // Per-channel next count

	// Per-channel reload and tick countdown
	for (genvar i = 0; i < NUM_TIMERS; i++)
	begin : g_chan
		localparam logic [TIMER_W-1:0] DUR = (i < NUM_HELD) ? HOLD_T : PULSE_T;
		assign cnt_next[i] = tmr.start[i] ? DUR :
			(tmr.tick && state_reg.cnt[i] != '0) ? state_reg.cnt[i] - 1'b1 :
			state_reg.cnt[i];
	end

	// Next state assembly
	always_comb
	begin
		state_next = state_reg;
		state_next.cnt = cnt_next;
		for (int i = 0; i < NUM_TIMERS; i++)
		begin
			state_next.act[i] = (cnt_next[i] != '0);
		end
	end

	// State register
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			state_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign tmr.active = state_reg.act;

endmodule

// File: irrcd_timer_if.sv
/*
 * Link between the decoder core and its output timer bank.
 * Assumes both ends run on the same clock and reset.
 */
`timescale 1ns/1ps
interface irrcd_timer_if;
	import irrcd_pkg::*;

	logic tick;                    // One-cycle oscillator tick
	logic [NUM_TIMERS-1:0] start;  // One-cycle reload per channel
	logic [NUM_TIMERS-1:0] active; // Channel still counting

	modport ctrl
	(
		output tick,
		output start,
		input active
	);
	modport bank
	(
		input tick,
		input start,
		output active
	);
endinterface

// File: irrcd_top.sv
/*
 * Infrared remote command decoder core: synchronises the demodulated command
 * input and the code-select pins, decodes bits by edge interval, checks the
 * repeated word against the stored one, compares the custom code and drives
 * held, one-shot and toggle outputs.
 * Assumes a demodulated, active-high pulse stream and an asynchronous,
 * active-low reset standing in for power-on reset.
 */
`timescale 1ns/1ps
module irrcd_top
	import irrcd_pkg::*;
#(
	parameter bit LARGE_VARIANT_P = 1'b1,
	parameter logic [DIV_W-1:0] TICK_CYCLES_P = DIV_W'(TICK_CYCLES),
	parameter logic [TIMER_W-1:0] HOLD_TICKS_P = TIMER_W'(HOLD_TICKS),
	parameter logic [TIMER_W-1:0] PULSE_TICKS_P = TIMER_W'(PULSE_TICKS)
)
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rstn_i,
	// Demodulated command stream
	input wire logic ir_command_in_i,
	// Code-select pins: level and whether something drives it
	input wire logic [1:0] code_sel_i,
	input wire logic [1:0] code_sel_drv_i,
	// Function outputs
	output logic [NUM_HELD-1:0] held_output_o,
	output logic [NUM_SINGLE-1:0] oneshot_output_o,
	output logic [NUM_TOGGLE-1:0] toggle_output_o,
	// Command accepted, one cycle
	output logic latch_o
);

	// Whole state of the core
	typedef struct packed
	{
		logic [4:0] meta;              // First synchroniser stage
		logic [4:0] sync;              // Second synchroniser stage
		logic in_prev;                 // Last synchronised command level
		logic [DIV_W-1:0] div;         // Tick divider
		logic tick;                    // Oscillator tick
		irrcd_rx_type rx;              // Receiver state
		logic [3:0] bitcnt;            // Bits in current word
		logic [IVL_W-1:0] ivl;         // Ticks since last edge
		logic [WORD_W-1:0] word;       // Stored command word
		logic [TIMER_W-1:0] press;     // Same-press window
		logic [WORD_W-1:0] last;       // Last accepted word
		logic [NUM_TOGGLE-1:0] tog;    // Toggle outputs
		logic [NUM_TIMERS-1:0] start;  // Timer reloads
		logic latch;                   // Accept pulse
	} irrcd_core_type;

	irrcd_core_type state_reg;
	irrcd_core_type state_next;

	irrcd_timer_if tmr_if();

	// Output timers for held and one-shot outputs
	irrcd_timer_bank
	#(
		.HOLD_T(HOLD_TICKS_P),
		.PULSE_T(PULSE_TICKS_P)
	)
	u_bank
	(
		.clk_i(clk_i),
		.rstn_i(rstn_i),
		.tmr(tmr_if.bank)
	);

	// Decoding helpers
	logic in_lvl;                  // Synchronised command input
	logic edge_seen;               // Rising edge of command input
	logic bit_val;                 // Decoded bit from interval
	logic [1:0] code_pin;          // Code pins after pull-up
	logic [2:0] code_exp;          // Expected custom code C1..C3
	logic [WORD_W-1:0] rx_word;    // Word as checked
	logic word_done;               // Second word fully matched
	logic code_ok;                 // Custom code agrees
	logic is_cont;                 // Continuous command
	logic is_single;               // Single command, first group
	logic is_grp2;                 // Single or toggle, second group
	logic is_repeat;               // Same key still held
	logic [DATA_W-1:0] dbits;      // Data field D1..D6
	logic [5:0] held_mask;         // Held outputs of this variant

	assign in_lvl = state_reg.sync[0];
	assign edge_seen = in_lvl && !state_reg.in_prev;
	assign bit_val = (state_reg.ivl >= BIT_ONE_TICKS);
	assign held_mask = LARGE_VARIANT_P ? HELD_MASK_LARGE : HELD_MASK_SMALL;

	// Pull-up on undriven code pins
	always_comb
	begin
		for (int i = 0; i < 2; i++)
		begin
			code_pin[i] = state_reg.sync[3+i] ? state_reg.sync[1+i] : 1'b1;
		end
	end

	// Expected code: fixed one on the unused code bit
	always_comb
	begin
		if (LARGE_VARIANT_P)
		begin
			code_exp = {code_pin[0], code_pin[1], 1'b1};
		end
		else
		begin
			code_exp = {1'b1, code_pin[0], code_pin[1]};
		end
	end

	// Command classification of the word being completed
	always_comb
	begin
		rx_word = {state_reg.word[WORD_W-2:0], state_reg.word[WORD_W-1]};
		word_done = (state_reg.rx == RX_SECOND) && edge_seen
			&& (state_reg.ivl < WORD_GAP_TICKS) && (bit_val == state_reg.word[WORD_W-1])
			&& (state_reg.bitcnt == 4'(LAST_BIT));
		code_ok = (rx_word[POS_C1:POS_C3] == code_exp);
		is_cont = rx_word[POS_CT] && !rx_word[POS_S1] && !rx_word[POS_S2];
		is_single = !rx_word[POS_CT] && rx_word[POS_S1] && !rx_word[POS_S2];
		is_grp2 = !rx_word[POS_CT] && !rx_word[POS_S1] && rx_word[POS_S2];
		dbits = rx_word[DATA_W-1:0];
		is_repeat = (state_reg.press != '0) && (rx_word == state_reg.last);
	end

	// Next-state logic
	always_comb
	begin
		state_next = state_reg;
		// Two-stage synchronisers
		state_next.meta = {code_sel_drv_i, code_sel_i, ir_command_in_i};
		state_next.sync = state_reg.meta;
		state_next.in_prev = in_lvl;
		state_next.start = '0;
		state_next.latch = 1'b0;

		// Oscillator tick from the system clock
		if (state_reg.div >= TICK_CYCLES_P - 1'b1)
		begin
			state_next.div = '0;
			state_next.tick = 1'b1;
		end
		else
		begin
			state_next.div = state_reg.div + 1'b1;
			state_next.tick = 1'b0;
		end

		// Interval count, restarted by every rising edge
		if (edge_seen)
		begin
			state_next.ivl = '0;
		end
		else if (state_reg.tick && state_reg.ivl != TIMEOUT_TICKS)
		begin
			state_next.ivl = state_reg.ivl + 1'b1;
		end

		// Same-press window countdown
		if (state_reg.tick && state_reg.press != '0)
		begin
			state_next.press = state_reg.press - 1'b1;
		end

		// Receiver sequence
		case (state_reg.rx)
			RX_IDLE:
			begin
				// First edge opens a frame
				if (edge_seen)
				begin
					state_next.rx = RX_FIRST;
					state_next.bitcnt = '0;
				end
			end
			RX_FIRST:
			begin
				if (state_reg.ivl == TIMEOUT_TICKS)
				begin
					state_next.rx = RX_IDLE;
				end
				else if (edge_seen && state_reg.ivl >= WORD_GAP_TICKS)
				begin
					// Overlong bit: treat edge as a fresh start
					state_next.bitcnt = '0;
				end
				else if (edge_seen)
				begin
					// Store the first word
					state_next.word = {state_reg.word[WORD_W-2:0], bit_val};
					state_next.bitcnt = state_reg.bitcnt + 1'b1;
					if (state_reg.bitcnt == 4'(LAST_BIT))
					begin
						state_next.rx = RX_WAIT2;
					end
				end
			end
			RX_WAIT2:
			begin
				if (state_reg.ivl == TIMEOUT_TICKS)
				begin
					state_next.rx = RX_IDLE;
				end
				else if (edge_seen && state_reg.ivl >= WORD_GAP_TICKS)
				begin
					state_next.rx = RX_SECOND;
					state_next.bitcnt = '0;
				end
				else if (edge_seen)
				begin
					state_next.rx = RX_IDLE;
				end
			end
			RX_SECOND:
			begin
				if (state_reg.ivl == TIMEOUT_TICKS)
				begin
					state_next.rx = RX_IDLE;
				end
				else if (edge_seen)
				begin
					if (state_reg.ivl >= WORD_GAP_TICKS || bit_val != state_reg.word[WORD_W-1])
					begin
						// Overlong interval or pushed-out bit disagrees: drop the frame
						state_next.rx = RX_IDLE;
					end
					else
					begin
						// Rotate so the stored word survives the check
						state_next.word = rx_word;
						state_next.bitcnt = state_reg.bitcnt + 1'b1;
						if (word_done)
						begin
							state_next.rx = RX_IDLE;
						end
					end
				end
			end
			default:
			begin
				state_next.rx = RX_IDLE;
			end
		endcase

		// Accept a fully matched word with agreeing code
		if (word_done && code_ok)
		begin
			state_next.latch = 1'b1;
			state_next.last = rx_word;
			state_next.press = HOLD_TICKS_P;
			if (is_cont)
			begin
				// Each held output whose data bit is set and within held_mask reloads its hold time
				state_next.start[NUM_HELD-1:0] = dbits & held_mask;
			end
			if (is_single && !is_repeat)
			begin
				state_next.start[NUM_HELD +: DATA_W] = dbits & held_mask;
			end
			if (is_grp2 && !is_repeat && LARGE_VARIANT_P)
			begin
				state_next.start[NUM_HELD+DATA_W +: 4] = dbits[3:0];
				state_next.tog = state_reg.tog ^ dbits[5:4];
			end
		end
	end

	// State register
	always_ff @(posedge clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			state_reg <= '0;
			state_reg.rx <= RX_IDLE;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// Link to timers and outputs
	assign tmr_if.tick = state_reg.tick;
	assign tmr_if.start = state_reg.start;
	assign held_output_o = tmr_if.active[NUM_HELD-1:0];
	assign oneshot_output_o = tmr_if.active[NUM_TIMERS-1:NUM_HELD];
	assign toggle_output_o = state_reg.tog;
	assign latch_o = state_reg.latch;

endmodule

// File: irrcd_top_tb.sv
/* Self-checking bench of the command decoder with shortened times.
   Assumes the transmitter model and the bound checker. */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin failures++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module irrcd_top_tb;
	import irrcd_pkg::*;
	localparam int HT = 1200 * 4; // Hold time in clocks
	localparam int PT = 100 * 4; // Pulse time in clocks
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic ir;
	logic [1:0] code_sel = 2'b00;
	logic [1:0] code_sel_drv = 2'b00;
	logic [NUM_HELD-1:0] held;
	logic [NUM_SINGLE-1:0] os;
	logic [NUM_TOGGLE-1:0] tog;
	logic latch;
	logic [NUM_HELD-1:0] held_sm; // Small variant outputs
	logic [NUM_SINGLE-1:0] os_sm;
	logic [NUM_TOGGLE-1:0] tog_sm;
	logic [NUM_HELD-1:0] s_held_sm; // Small variant snapshot
	logic [NUM_SINGLE-1:0] s_os_sm;
	logic [NUM_TOGGLE-1:0] s_tog_sm;
	logic [NUM_HELD-1:0] s_held; // Outputs one cycle after latch
	logic [NUM_SINGLE-1:0] s_os;
	logic [NUM_TOGGLE-1:0] s_tog;
	int failures = 0;
	int n_checks = 0;
	int cyc = 0;
	int last = 0;
	int n_latch = 0;
	int n;
	always #20 clk = ~clk;
	irrcd_ir_tx_model u_irrcd_ir_tx_model (.clk_i(clk), .ir_o(ir));
	irrcd_top #(.LARGE_VARIANT_P(1'b1), .TICK_CYCLES_P(10'h004), .HOLD_TICKS_P(13'h04B0),
		.PULSE_TICKS_P(13'h0064)) u_irrcd_top (.clk_i(clk), .rstn_i(rstn), .ir_command_in_i(ir),
		.code_sel_i(code_sel), .code_sel_drv_i(code_sel_drv), .held_output_o(held),
		.oneshot_output_o(os), .toggle_output_o(tog), .latch_o(latch));
	// Small variant on the same stimulus
	irrcd_top #(.LARGE_VARIANT_P(1'b0), .TICK_CYCLES_P(10'h004), .HOLD_TICKS_P(13'h04B0),
		.PULSE_TICKS_P(13'h0064)) u_irrcd_top_small (.clk_i(clk), .rstn_i(rstn),
		.ir_command_in_i(ir), .code_sel_i(code_sel), .code_sel_drv_i(code_sel_drv),
		.held_output_o(held_sm), .oneshot_output_o(os_sm), .toggle_output_o(tog_sm),
		.latch_o());
	// Latch monitor and output snapshot, off the active edge
	always @(negedge clk)
	begin
		cyc++;
		if (latch === 1'b1)
		begin
			n_latch++;
			last = cyc;
		end
		if (cyc == last + 1)
		begin
			s_held = held;
			s_os = os;
			s_tog = tog;
			s_held_sm = held_sm;
			s_os_sm = os_sm;
			s_tog_sm = tog_sm;
		end
	end
	task automatic results();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// Bounded wait for a cycle count
	task automatic wait_to(input int t);
		int k;
		for (k = 0; k < 30000 && cyc < t; k++)
			@(negedge clk);
		if (cyc < t)
		begin
			failures++;
			results();
		end
	endtask
	// Three keys held over two frames, floating code pins
	task automatic t_cont();
		u_irrcd_ir_tx_model.send(12'hF25, 12'hF25);
		`CHK("held first", 6'h25, s_held)
		`CHK("small held", 6'h05, s_held_sm)
		u_irrcd_ir_tx_model.send(12'hF25, 12'hF25);
		`CHK("held kept", 6'h25, held)
		wait_to(last + HT - 8);
		`CHK("held before drop", 6'h25, held)
		wait_to(last + HT + 8);
		`CHK("held dropped", 6'h00, held)
		$display("test cont done");
	endtask
	// One-shot from both single groups
	task automatic t_single();
		u_irrcd_ir_tx_model.send(12'hE81, 12'hE81);
		`CHK("pulse start", 10'h001, s_os)
		`CHK("small pulse", 10'h001, s_os_sm)
		wait_to(last + PT - 8);
		`CHK("pulse high", 10'h001, os)
		wait_to(last + PT + 8);
		`CHK("pulse end", 10'h000, os)
		u_irrcd_ir_tx_model.send(12'hE41, 12'hE41);
		`CHK("second group", 10'h040, s_os)
		`CHK("small group2", 10'h000, s_os_sm)
		$display("test single done");
	endtask
	// Toggle twice, past the press window
	task automatic t_toggle();
		u_irrcd_ir_tx_model.send(12'hE50, 12'hE50);
		`CHK("toggle on", 2'b01, s_tog)
		`CHK("small toggle", 2'b00, s_tog_sm)
		wait_to(last + HT + 8);
		u_irrcd_ir_tx_model.send(12'hE50, 12'hE50);
		`CHK("toggle off", 2'b00, s_tog)
		$display("test toggle done");
	endtask
	// Repeat word differing in its last bit
	task automatic t_badrep();
		n = n_latch;
		u_irrcd_ir_tx_model.send(12'hF25, 12'hF24);
		`CHK("no latch", n, n_latch)
		`CHK("held idle", 6'h00, held)
		$display("test repeat done");
	endtask
	// Driven code pins, wrong then right code
	task automatic t_code();
		@(posedge clk);
		code_sel_drv <= 2'b11;
		code_sel <= 2'b01;
		n = n_latch;
		u_irrcd_ir_tx_model.send(12'hF25, 12'hF25);
		`CHK("wrong code latch", n, n_latch)
		`CHK("wrong code held", 6'h00, held)
		u_irrcd_ir_tx_model.send(12'hB02, 12'hB02);
		`CHK("right code latch", n + 1, n_latch)
		`CHK("right code held", 6'h02, s_held)
		`CHK("small code held", 6'h00, s_held_sm)
		$display("test code done");
	endtask
	// Main sequence
	initial
	begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		t_cont();
		t_single();
		t_toggle();
		t_badrep();
		t_code();
		results();
	end
endmodule
